/* hdl/mark_store.sv */
// Sector mark memory: one pseudo and one flagged bit per tracked sector.
// Assumes the backing array is held by always-on retained storage.
`timescale 1ns/1ps
module mark_store #(
  parameter int ADDR_W = 10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_set_en,
  input wire logic i_set_pseudo,
  input wire logic [ADDR_W-1:0] i_set_addr,
  input wire logic i_clr_en,
  input wire logic [ADDR_W-1:0] i_clr_addr,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic o_pseudo,
  output logic o_flagged
);

  logic [1:0] marks_q [0:(1<<ADDR_W)-1];

  // ****************************************************************
  // Storage; reset does not clear marks so they persist.
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_set_en)
    begin
      marks_q[i_set_addr] <= {~i_set_pseudo, i_set_pseudo} | marks_q[i_set_addr];
    end
    if (i_clr_en && !(i_set_en && i_set_addr == i_clr_addr))
    begin
      marks_q[i_clr_addr] <= 2'h0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_pseudo <= 1'b0;
      o_flagged <= 1'b0;
    end
    else
    begin
      o_pseudo <= marks_q[i_rd_addr][0];
      o_flagged <= marks_q[i_rd_addr][1];
    end
  end

endmodule : mark_store

/* hdl/wrunc_ctrl.sv */
// Command interpreter for the mark-uncorrectable command and media access checking.
// Assumes task-file values and media requests come from same-clock controller logic.
`timescale 1ns/1ps
// What this block does
// - Opcode 45h starts the mark command using 48-bit current and previous registers.
// - Feature 55h marks every sector of the containing physical block, logged.
// - Reads of pseudo marked sectors run full recovery, then report data error.
// - Feature AAh flags only addressed sectors; later reads report data error.
// - Any other feature value aborts the command.
// - Sector count is previous:current; zero means 65,536 sectors.
// - Start address assembled from current and previous address registers.
// - First error address returned in low and high address byte banks.
// - Every read-type command reports data error on a marked sector.
// - A write to a marked sector clears its mark.
// - A real defect reports error status matching that defect.
// - Marks are kept in retained storage across power cycles.
// - A command that cannot be carried out is aborted, never partial.
// - Completion shows busy, fault, corrected clear; only id, abort and uncorrectable errors.
module wrunc_ctrl #(
  parameter int ADDR_W = 10,
  parameter int BLOCK_SHIFT = 3
) (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic i_cmd_valid,
  input wire wrunc_pkg::taskfile_t i_taskfile,
  input wire wrunc_pkg::media_req_t i_media,
  input wire logic i_hob,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_error_flags,
  output logic [7:0] o_command_status,
  output logic [7:0] o_sect_rd,
  output logic [7:0] o_cyl_lo_rd,
  output logic [7:0] o_cyl_hi_rd
);

  if (ADDR_W < 1 || ADDR_W > 20 || BLOCK_SHIFT < 0 || BLOCK_SHIFT > ADDR_W)
  begin : g_bad_params
    $error("wrunc_ctrl: bad parameters");
  end

  wrunc_pkg::state_t state_q;
  logic [47:0] lba_q;
  logic [47:0] last_q;
  logic [47:0] err_lba_q;
  logic [16:0] left_q;
  logic pseudo_q;
  logic is_write_q;
  logic defect_q;
  logic [7:0] rec_cnt_q;
  logic [47:0] start_lba;
  logic [16:0] count;
  logic [47:0] blk_mask;
  logic set_en;
  logic clr_en;
  logic [ADDR_W-1:0] rd_addr;
  logic mark_pseudo;
  logic mark_flagged;
  logic access_wait_q;
  logic abort_mark_q;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic option_ok(input logic [7:0] f);
    option_ok = (f == wrunc_pkg::OPT_PSEUDO) || (f == wrunc_pkg::OPT_FLAGGED);
  endfunction : option_ok

  function automatic logic [ADDR_W-1:0] slot(input logic [47:0] a);
    slot = a[ADDR_W-1:0];
  endfunction : slot

  assign start_lba = {i_taskfile.cyl_hi_prev, i_taskfile.cyl_lo_prev, i_taskfile.sect_prev,
                      i_taskfile.cyl_hi_cur, i_taskfile.cyl_lo_cur, i_taskfile.sect_cur};
  assign count = ({i_taskfile.count_prev, i_taskfile.count_cur} == 16'h0000) ?
                 wrunc_pkg::COUNT_ZERO_MEANS :
                 {1'b0, i_taskfile.count_prev, i_taskfile.count_cur};
  assign blk_mask = ~((48'h1 << BLOCK_SHIFT) - 48'h1);

  logic cmd_start;
  logic cmd_bad;
  logic mark_range_bad;
  assign cmd_start = (state_q == wrunc_pkg::ST_IDLE) && i_cmd_valid &&
                     (i_taskfile.command == wrunc_pkg::CMD_MARK_UNC);
  assign cmd_bad = !option_ok(i_taskfile.feature);
  assign mark_range_bad = (start_lba + {31'h0, count} - 48'h1) >= (48'h1 << ADDR_W);

  logic media_start;
  assign media_start = (state_q == wrunc_pkg::ST_IDLE) && !i_cmd_valid && i_media.valid;

  // ****************************************************************
  // Mark storage
  // ****************************************************************
  assign set_en = (state_q == wrunc_pkg::ST_MARK) && (left_q != 17'h0);
  assign clr_en = (state_q == wrunc_pkg::ST_ACCESS_DONE) && is_write_q;
  assign rd_addr = slot(lba_q);

  mark_store #(
    .ADDR_W(ADDR_W)
  ) u_store (
    .i_clk(I_CLOCK),
    .i_srst(I_SRST),
    .i_set_en(set_en),
    .i_set_pseudo(pseudo_q),
    .i_set_addr(slot(lba_q)),
    .i_clr_en(clr_en),
    .i_clr_addr(slot(lba_q)),
    .i_rd_addr(rd_addr),
    .o_pseudo(mark_pseudo),
    .o_flagged(mark_flagged)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      state_q <= wrunc_pkg::ST_IDLE;
    end
    else
    begin
      case (state_q)
        wrunc_pkg::ST_IDLE:
        begin
          if (cmd_start)
          begin
            state_q <= (cmd_bad || mark_range_bad) ? wrunc_pkg::ST_DONE : wrunc_pkg::ST_MARK;
          end
          else if (media_start)
          begin
            state_q <= wrunc_pkg::ST_RECOVER;
          end
        end
        wrunc_pkg::ST_MARK:
        begin
          if (left_q == 17'h0 || lba_q == last_q)
          begin
            state_q <= wrunc_pkg::ST_DONE;
          end
        end
        wrunc_pkg::ST_RECOVER:
        begin
          if (!access_wait_q)
          begin
            state_q <= wrunc_pkg::ST_ACCESS_DONE;
          end
        end
        wrunc_pkg::ST_ACCESS_DONE:
        begin
          state_q <= wrunc_pkg::ST_IDLE;
        end
        wrunc_pkg::ST_DONE:
        begin
          state_q <= wrunc_pkg::ST_IDLE;
        end
        default:
        begin
          state_q <= wrunc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Address walk
  // ****************************************************************
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      lba_q <= 48'h0;
      last_q <= 48'h0;
      left_q <= 17'h0;
      pseudo_q <= 1'b0;
      is_write_q <= 1'b0;
      defect_q <= 1'b0;
    end
    else if (cmd_start)
    begin
      pseudo_q <= (i_taskfile.feature == wrunc_pkg::OPT_PSEUDO);
      if (i_taskfile.feature == wrunc_pkg::OPT_PSEUDO)
      begin
        lba_q <= start_lba & blk_mask;
        last_q <= (start_lba + {31'h0, count} - 48'h1) | ~blk_mask;
        left_q <= 17'h1ffff;
      end
      else
      begin
        lba_q <= start_lba;
        last_q <= start_lba + {31'h0, count} - 48'h1;
        left_q <= count;
      end
    end
    else if (media_start)
    begin
      lba_q <= i_media.lba;
      is_write_q <= i_media.is_write;
      defect_q <= i_media.defect;
    end
    else if (set_en && lba_q != last_q)
    begin
      lba_q <= lba_q + 48'h1;
      left_q <= left_q - 17'h1;
    end
  end

  // ****************************************************************
  // Recovery wait for reads of pseudo marked sectors
  // ****************************************************************
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      rec_cnt_q <= 8'h0;
      access_wait_q <= 1'b0;
    end
    else if (media_start)
    begin
      rec_cnt_q <= 8'h0;
      access_wait_q <= 1'b1;
    end
    else if (state_q == wrunc_pkg::ST_RECOVER)
    begin
      // The mark output lags the address by one cycle, so the first cycle is skipped.
      if (rec_cnt_q != 8'h0 &&
          (is_write_q || !mark_pseudo || rec_cnt_q == 8'(wrunc_pkg::RECOVERY_CYCLES)))
      begin
        access_wait_q <= 1'b0;
      end
      rec_cnt_q <= rec_cnt_q + 8'h1;
    end
  end

  // ****************************************************************
  // Status, error and error address reporting
  // ****************************************************************
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      o_error_flags <= wrunc_pkg::ERROR_FLAGS_RST;
      o_command_status <= wrunc_pkg::STATUS_RST;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      err_lba_q <= 48'h0;
    end
    else
    begin
      o_done <= 1'b0;
      o_busy <= (state_q != wrunc_pkg::ST_IDLE) || cmd_start || media_start;
      if (cmd_start || media_start)
      begin
        o_command_status <= 8'h80;
        o_error_flags <= 8'h00;
      end
      else if (state_q == wrunc_pkg::ST_DONE)
      begin
        o_done <= 1'b1;
        o_error_flags <= 8'h00;
        o_command_status <= wrunc_pkg::STATUS_RST;
        if (abort_mark_q)
        begin
          o_error_flags[wrunc_pkg::ERR_ABORTED_BIT] <= 1'b1;
          o_command_status[wrunc_pkg::ST_ERR_BIT] <= 1'b1;
          err_lba_q <= 48'h0;
        end
      end
      else if (state_q == wrunc_pkg::ST_ACCESS_DONE)
      begin
        o_done <= 1'b1;
        o_command_status <= wrunc_pkg::STATUS_RST;
        o_error_flags <= 8'h00;
        if (defect_q)
        begin
          o_error_flags[wrunc_pkg::ERR_UNC_BIT] <= 1'b1;
          o_command_status[wrunc_pkg::ST_ERR_BIT] <= 1'b1;
          err_lba_q <= lba_q;
        end
        else if (!is_write_q && (mark_pseudo || mark_flagged))
        begin
          o_error_flags[wrunc_pkg::ERR_UNC_BIT] <= 1'b1;
          o_command_status[wrunc_pkg::ST_ERR_BIT] <= 1'b1;
          err_lba_q <= lba_q;
        end
      end
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      abort_mark_q <= 1'b0;
    end
    else if (cmd_start)
    begin
      abort_mark_q <= cmd_bad || mark_range_bad;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      o_sect_rd <= 8'h00;
      o_cyl_lo_rd <= 8'h00;
      o_cyl_hi_rd <= 8'h00;
    end
    else
    begin
      o_sect_rd <= i_hob ? err_lba_q[31:24] : err_lba_q[7:0];
      o_cyl_lo_rd <= i_hob ? err_lba_q[39:32] : err_lba_q[15:8];
      o_cyl_hi_rd <= i_hob ? err_lba_q[47:40] : err_lba_q[23:16];
    end
  end

endmodule : wrunc_ctrl

/* hdl/wrunc_pkg.sv */
// Package for the mark-uncorrectable command block: opcodes, options, bit positions, types.
// Assumes a single 250 MHz controller clock and a synchronous active-high reset.
package wrunc_pkg;

  // ****************************************************************
  // Command and option codes
  // ****************************************************************
  localparam logic [7:0] CMD_MARK_UNC = 8'h45;
  localparam logic [7:0] OPT_PSEUDO = 8'h55;
  localparam logic [7:0] OPT_FLAGGED = 8'haa;

  // ****************************************************************
  // Error and status bit positions
  // ****************************************************************
  localparam int ERR_ADDR_MARK_MISSING_BIT = 0;
  localparam int ERR_TIMEOUT_BIT = 1;
  localparam int ERR_ABORTED_BIT = 2;
  localparam int ERR_ID_NOT_FOUND_BIT = 4;
  localparam int ERR_UNC_BIT = 6;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_BSY_BIT = 7;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] ERROR_FLAGS_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h50;
  localparam int RECOVERY_NS = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] COUNT_ZERO_MEANS = 17'h10000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] sect_cur;
    logic [7:0] sect_prev;
    logic [7:0] cyl_lo_cur;
    logic [7:0] cyl_lo_prev;
    logic [7:0] cyl_hi_cur;
    logic [7:0] cyl_hi_prev;
    logic [7:0] command;
  } taskfile_t;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic [47:0] lba;
    logic defect;
  } media_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MARK = 3'b001,
    ST_DONE = 3'b011,
    ST_RECOVER = 3'b010,
    ST_ACCESS_DONE = 3'b110
  } state_t;

endpackage : wrunc_pkg

/* tb/host_model.sv */
// Host side model: loads the task file, issues commands and sector accesses.
// Assumes requests are made one at a time by the testbench.
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk,
  output wrunc_pkg::taskfile_t o_taskfile,
  output logic o_cmd_valid,
  output wrunc_pkg::media_req_t o_media,
  output logic o_hob
);
  initial
  begin
    o_cmd_valid = 1'b0;
    o_taskfile = '0;
    o_media = '0;
    o_hob = 1'b0;
  end
  task automatic send_cmd(input logic [7:0] f, input logic [15:0] c, input logic [47:0] l);
    @(negedge i_clk);
    o_taskfile.feature = f;
    {o_taskfile.count_prev, o_taskfile.count_cur} = c;
    {o_taskfile.cyl_hi_prev, o_taskfile.cyl_lo_prev, o_taskfile.sect_prev,
      o_taskfile.cyl_hi_cur, o_taskfile.cyl_lo_cur, o_taskfile.sect_cur} = l;
    o_taskfile.command = wrunc_pkg::CMD_MARK_UNC;
    o_cmd_valid = 1'b1;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_taskfile = ~o_taskfile;
  endtask : send_cmd
  task automatic access(input logic w, input logic [47:0] l, input logic d);
    @(negedge i_clk);
    o_media = '{valid: 1'b1, is_write: w, lba: l, defect: d};
    @(negedge i_clk);
    o_media = '{valid: 1'b0, is_write: ~w, lba: ~l, defect: ~d};
  endtask : access
  task automatic set_hob(input logic h);
    @(negedge i_clk);
    o_hob = h;
  endtask : set_hob
endmodule : host_model

/* tb/test_wrunc_ctrl.sv */
// Testbench for wrunc_ctrl: marking, reads, writes and aborts against a mark model.
// Assumes host_model drives every design input at the falling edge.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_wrunc_ctrl;
  logic I_CLOCK, I_SRST, cmd_valid, hob, busy, done, w;
  logic [7:0] err, stat, sect_rd, lo_rd, hi_rd;
  wrunc_pkg::taskfile_t taskfile;
  wrunc_pkg::media_req_t media;
  int failures, total_checks, seed;
  logic [15:0] exp_q[$];
  logic [15:0] exp_v;
  bit marked[1024];
  logic [9:0] a;
  logic [7:0] bad_f[5] = '{8'h00, 8'h54, 8'h56, 8'ha9, 8'hff};
  logic [9:0] probe[8] = '{10'd99, 10'd100, 10'd103, 10'd104, 10'd7, 10'd8, 10'd15, 10'd16};
  wrunc_ctrl #(.ADDR_W(10), .BLOCK_SHIFT(3)) u_wrunc_ctrl (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
    .i_cmd_valid(cmd_valid), .i_taskfile(taskfile), .i_media(media), .i_hob(hob),
    .o_busy(busy), .o_done(done), .o_error_flags(err), .o_command_status(stat),
    .o_sect_rd(sect_rd), .o_cyl_lo_rd(lo_rd), .o_cyl_hi_rd(hi_rd));
  host_model u_host_model (.i_clk(I_CLOCK), .o_taskfile(taskfile), .o_cmd_valid(cmd_valid),
    .o_media(media), .o_hob(hob));
  initial
  begin
    I_CLOCK = 1'b0;
    forever #2 I_CLOCK = ~I_CLOCK;
  end
  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(negedge I_CLOCK)
    if (done === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK("unexpected done", 1'b0, 1'b1)
      else
      begin
        exp_v = exp_q.pop_front();
        `CHK("error and status", exp_v, {err, stat})
      end
    end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 3000)
    begin
      @(negedge I_CLOCK);
      k++;
    end
    if (k >= 3000)
    begin
      failures++;
      final_report();
    end
    @(negedge I_CLOCK);
  endtask : wait_done
  task automatic cmd(input logic [7:0] f, input logic [15:0] c, input logic [47:0] l,
    input logic [15:0] e);
    exp_q.push_back(e);
    u_host_model.send_cmd(f, c, l);
    wait_done();
  endtask : cmd
  task automatic mark(input logic [7:0] f, input logic [15:0] c, input logic [9:0] s);
    logic [9:0] t;
    cmd(f, c, {38'h0, s}, 16'h0050);
    for (int k = 0; k < c; k++)
    begin
      t = s + 10'(k);
      if (f == wrunc_pkg::OPT_PSEUDO)
        for (int j = 0; j < 8; j++)
          marked[{t[9:3], 3'(j)}] = 1'b1;
      else
        marked[t] = 1'b1;
    end
  endtask : mark
  task automatic acc(input logic wr, input logic [9:0] s, input logic d);
    logic bad;
    bad = (!wr && marked[s]) || d;
    if (wr)
      marked[s] = 1'b0;
    exp_q.push_back(bad ? 16'h4051 : 16'h0050);
    u_host_model.access(wr, {38'h0, s}, d);
    wait_done();
    if (bad)
    begin
      u_host_model.set_hob(1'b0);
      repeat (2) @(negedge I_CLOCK);
      `CHK("low address", {14'h0, s}, {hi_rd, lo_rd, sect_rd})
      u_host_model.set_hob(1'b1);
      repeat (2) @(negedge I_CLOCK);
      `CHK("high address", 24'h0, {hi_rd, lo_rd, sect_rd})
    end
  endtask : acc
  task automatic do_reset();
    I_SRST = 1'b1;
    repeat (12) @(negedge I_CLOCK);
    I_SRST = 1'b0;
  endtask : do_reset
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = 90;
    do_reset();
    foreach (bad_f[k]) cmd(bad_f[k], 16'h0001, 48'h5, 16'h0451);
    mark(wrunc_pkg::OPT_FLAGGED, 16'h0004, 10'd100);
    mark(wrunc_pkg::OPT_PSEUDO, 16'h0002, 10'd13);
    foreach (probe[k]) acc(1'b0, probe[k], 1'b0);
    acc(1'b1, 10'd100, 1'b0);
    acc(1'b0, 10'd100, 1'b0);
    acc(1'b0, 10'd500, 1'b1);
    cmd(wrunc_pkg::OPT_FLAGGED, 16'h0000, 48'h0, 16'h0451);
    cmd(wrunc_pkg::OPT_PSEUDO, 16'h0004, 48'h3fe, 16'h0451);
    mark(wrunc_pkg::OPT_FLAGGED, 16'h0004, 10'd1020);
    do_reset();
    acc(1'b0, 10'd101, 1'b0);
    acc(1'b0, 10'd1023, 1'b0);
    repeat (40)
    begin
      a = 10'($random(seed));
      w = 1'($random(seed));
      repeat (a[1:0]) @(negedge I_CLOCK);
      acc(w, a, 1'b0);
    end
    final_report();
  end
endmodule : test_wrunc_ctrl

/* tb/wrunc_ctrl_sva.sv */
// Port checker for the mark-uncorrectable command block.
// Assumes one clock and a synchronous active-high reset on the bound instance.
`timescale 1ns/1ps
module wrunc_checker (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic i_cmd_valid,
  input wire wrunc_pkg::taskfile_t i_taskfile,
  input wire wrunc_pkg::media_req_t i_media,
  input wire logic i_hob,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_error_flags,
  input wire logic [7:0] o_command_status,
  input wire logic [7:0] o_sect_rd,
  input wire logic [7:0] o_cyl_lo_rd,
  input wire logic [7:0] o_cyl_hi_rd
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  sequence s_take;
    !o_busy && i_cmd_valid && i_taskfile.command == wrunc_pkg::CMD_MARK_UNC;
  endsequence
  sequence s_bad;
    s_take ##0 (i_taskfile.feature != wrunc_pkg::OPT_PSEUDO &&
      i_taskfile.feature != wrunc_pkg::OPT_FLAGGED);
  endsequence
  sequence s_flag4;
    s_take ##0 (i_taskfile.feature == wrunc_pkg::OPT_FLAGGED &&
      {i_taskfile.count_prev, i_taskfile.count_cur} == 16'h0004);
  endsequence
  property p_take;
    s_take |=> o_busy && o_command_status[7];
  endproperty
  a_take: assert property (p_take) else $error("command not taken");
  property p_bad;
    s_bad |-> ##[1:3] (o_done && o_error_flags == 8'h04 && o_command_status == 8'h51);
  endproperty
  a_bad: assert property (p_bad) else $error("reserved option not aborted");
  property p_flag;
    s_flag4 |-> ##[4:8] o_done;
  endproperty
  a_flag: assert property (p_flag) else $error("flagged marking length wrong");
  property p_access;
    !o_busy && !i_cmd_valid && i_media.valid |-> ##[1:20] o_done;
  endproperty
  a_access: assert property (p_access) else $error("sector access not answered");
  property p_stat;
    o_done |-> (o_command_status & 8'hfe) == 8'h50;
  endproperty
  a_stat: assert property (p_stat) else $error("completion status wrong");
  property p_errbits;
    o_done |-> (o_error_flags & 8'hab) == 8'h00;
  endproperty
  a_errbits: assert property (p_errbits) else $error("illegal error bit set");
  property p_errstat;
    o_done |-> o_command_status[0] == (o_error_flags != 8'h00);
  endproperty
  a_errstat: assert property (p_errstat) else $error("error bit mismatch");
  property p_hold;
    !o_busy && !i_cmd_valid && !i_media.valid |=>
      $stable(o_error_flags) && $stable(o_command_status);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed while idle");
endmodule : wrunc_checker

bind wrunc_ctrl wrunc_checker u_wrunc_checker (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
  .i_cmd_valid(i_cmd_valid), .i_taskfile(i_taskfile), .i_media(i_media), .i_hob(i_hob),
  .o_busy(o_busy), .o_done(o_done), .o_error_flags(o_error_flags),
  .o_command_status(o_command_status), .o_sect_rd(o_sect_rd), .o_cyl_lo_rd(o_cyl_lo_rd),
  .o_cyl_hi_rd(o_cyl_hi_rd));
